// [verilog/reconfig_pkg.sv]
// Purpose: shared constants for the reconfiguration controller and its host
// Assumes: 10 MHz management clock
// Notes: word addresses on the management port, byte offsets on APB
package reconfig_pkg;
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int OC_TIME_US = 100;
	localparam int DCAL_TIME_US = 70;
	localparam int OC_CYCLES_PER_CH = OC_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int DCAL_CYCLES_PER_CH = DCAL_TIME_US * (CLK_FREQ_HZ / 1_000_000);

	// management port word addresses
	localparam logic [6:0] A_LCH = 7'h08;
	localparam logic [6:0] A_PHYS = 7'h09;
	localparam logic [6:0] A_CSR = 7'h0A;
	localparam logic [6:0] A_OFFS = 7'h0B;
	localparam logic [6:0] A_DATA = 7'h0C;
	localparam logic [6:0] A_S_LCH = 7'h38;
	localparam logic [6:0] A_S_BASE = 7'h39;
	localparam logic [6:0] A_S_CSR = 7'h3A;
	localparam logic [6:0] A_S_OFFS = 7'h3B;
	localparam logic [6:0] A_S_DATA = 7'h3C;

	// control and status bit positions
	localparam int B_WRITE = 0;
	localparam int B_READ = 1;
	localparam int B_DIRECT = 2;
	localparam int B_BUSY = 8;
	localparam int B_ERR = 9;

	// feature class lives in offset[5:3]
	localparam logic [2:0] F_ANALOG = 3'h0;
	localparam logic [2:0] F_LOOPBACK = 3'h1;
	localparam logic [2:0] F_ADAPTIVE_EQUALIZATION = 3'h2;
	localparam logic [2:0] F_EYE = 3'h3;
	localparam logic [2:0] F_AUXILIARY_TRANSMIT_PLL = 3'h4;
	localparam logic [2:0] F_TXPLL_SWITCH = 3'h5;
	localparam logic [2:0] F_REFCLK = 3'h6;
	localparam logic [2:0] F_CHANNEL = 3'h7;

	// file entry: word with bit 15 set ends the file, else offset then data
	localparam int MIF_END_BIT = 15;
	localparam logic [31:0] MIF_WORD_BYTES = 32'h0000_0002;

	// host APB byte offsets
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_ADDR = 8'h04;
	localparam logic [7:0] H_WDATA = 8'h08;
	localparam logic [7:0] H_RDATA = 8'h0C;
	localparam logic [7:0] H_STATUS = 8'h10;
endpackage

// [verilog/reconfig_mgmt_if.sv]
// Purpose: management port between embedded controller and reconfig controller
// Assumes: both ends on the same clock
// Notes: read data valid the cycle after the read strobe
`timescale 1ns/1ps
interface reconfig_mgmt_if;
	logic [6:0] mgmtAddress;
	logic [31:0] mgmtWritedata;
	logic [31:0] mgmtReaddata;
	logic mgmtWrite;
	logic mgmtRead;
	logic reconfigBusy;

	modport dev (
		input mgmtAddress,
		input mgmtWritedata,
		output mgmtReaddata,
		input mgmtWrite,
		input mgmtRead,
		output reconfigBusy
	);

	modport ctl (
		output mgmtAddress,
		output mgmtWritedata,
		input mgmtReaddata,
		output mgmtWrite,
		output mgmtRead,
		input reconfigBusy
	);
endinterface

// [verilog/reconfig_controller.sv]
// Purpose: reconfiguration controller, register mode and streamer mode
// Assumes: one clock, synchronous active-high reset, file memory on same clock
// Notes on behaviour
// - host starts reconfig by register reads/writes
// - management commands become per-interface bus transactions
// - streamer applies file updates to transceiver
// - file chosen by writes, then applied unattended
// - direct-write variant uses register reads/writes instead
// - loopback, equalization, eye, PLL tuning register-only
// - PLL switching/analog both; refclk, channel streamer-only
// - offset cancellation always runs once after reset
// - offset cancellation takes 100 us per channel
// - one interface per channel and per PLL
// - grouping list maps interfaces to PHY instances
// - channel/PLL option enables channel and PLL reconfig
// - PLL-only option enables PLL reconfig
// - analog option enables signal conditioning adjustments
// - duty cycle option adds duty cycle calibration
// - file master drives 32-bit byte address
// - file master reads 16-bit words with read strobe
// - file memory stalls with waitrequest when not ready
// - 7-bit word address, 32-bit data, read/write strobes
// - busy high during operations, host waits on it
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module reconfig_controller #(
	parameter int NUM_CH = 2,
	parameter int NUM_PLL = 1,
	parameter int NUM_GROUPS = 0,
	parameter logic [63:0] GROUP_SIZES = 64'h0,
	parameter bit ENABLE_DCAL = 1'b1,
	parameter bit ENABLE_ANALOG = 1'b1,
	parameter bit ENABLE_CH_PLL = 1'b1,
	parameter bit ENABLE_PLL_ONLY = 1'b0,
	parameter int OC_CYCLES = reconfig_pkg::OC_CYCLES_PER_CH,
	parameter int DCAL_CYCLES = reconfig_pkg::DCAL_CYCLES_PER_CH,
	parameter int NUM_IF = NUM_CH + NUM_PLL
) (
	input wire logic clock,
	input wire logic reset,
	reconfig_mgmt_if.dev mgmt,
	output logic [31:0] mifAddress,
	output logic mifRead,
	input wire logic [15:0] mifReaddata,
	input wire logic mifWaitrequest,
	output logic [NUM_IF-1:0] xcvrWrite,
	output logic [NUM_IF-1:0] xcvrRead,
	output logic [5:0] xcvrAddress,
	output logic [15:0] xcvrWritedata,
	input wire logic [NUM_IF*16-1:0] xcvrReaddata
);
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_CAL = 7'b0000010,
		S_XFER = 7'b0000100,
		S_F_ENTRY = 7'b0001000,
		S_F_DATA = 7'b0010000,
		S_APPLY = 7'b0100000,
		S_XDONE = 7'b1000000
	} state_t;

	typedef struct packed {
		state_t state;
		logic [9:0] lch;
		logic [5:0] offs;
		logic [15:0] data;
		logic [31:0] mifBase;
		logic errReg;
		logic errStr;
		logic direct;
		logic readOp;
		logic fromStream;
		logic dcalPhase;
		logic [23:0] calCnt;
		logic [31:0] rdata;
		logic busy;
		logic [31:0] mifAddr;
		logic mifRd;
		logic [NUM_IF-1:0] xWr;
		logic [NUM_IF-1:0] xRd;
		logic [5:0] xAddr;
		logic [15:0] xWdata;
	} ctl_t;

	ctl_t st_reg;
	ctl_t st_next;

	localparam logic [2:0] F_ANALOG_C = reconfig_pkg::F_ANALOG;
	localparam logic [2:0] F_TXPLL_C = reconfig_pkg::F_TXPLL_SWITCH;
	localparam logic [2:0] F_REFCLK_C = reconfig_pkg::F_REFCLK;
	localparam logic [2:0] F_CHANNEL_C = reconfig_pkg::F_CHANNEL;

	// physical address is {instance, index within instance}
	function automatic logic [9:0] physOf(input logic [9:0] l);
		logic [9:0] rem;
		logic [3:0] inst;
		rem = l;
		inst = 4'h0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if (rem >= {2'b00, GROUP_SIZES[g*8 +: 8]} && g < NUM_GROUPS - 1) begin
				rem = rem - {2'b00, GROUP_SIZES[g*8 +: 8]};
				inst = inst + 4'h1;
			end
		end
		return {inst, rem[5:0]};
	endfunction

	function automatic logic builtIn(input logic [2:0] cls);
		case (cls)
			F_ANALOG_C: return ENABLE_ANALOG;
			F_TXPLL_C, F_REFCLK_C: return ENABLE_CH_PLL | ENABLE_PLL_ONLY;
			F_CHANNEL_C: return ENABLE_CH_PLL;
			default: return 1'b1;
		endcase
	endfunction

	function automatic logic regModeOk(input logic [2:0] cls);
		return builtIn(cls) && cls != F_REFCLK_C && cls != F_CHANNEL_C;
	endfunction

	function automatic logic streamOk(input logic [2:0] cls);
		return builtIn(cls) && (cls == F_ANALOG_C || cls >= F_TXPLL_C);
	endfunction

	function automatic logic [NUM_IF-1:0] selOf(input logic [9:0] l);
		logic [NUM_IF-1:0] s;
		s = '0;
		for (int i = 0; i < NUM_IF; i++) begin
			s[i] = (l == 10'(i));
		end
		return s;
	endfunction

	logic lchOk;
	logic wrCsr;
	logic wrScsr;
	logic mifTaken;

	always_comb begin
		st_next = st_reg;
		lchOk = st_reg.lch < 10'(NUM_IF);
		wrCsr = mgmt.mgmtWrite && mgmt.mgmtAddress == reconfig_pkg::A_CSR;
		wrScsr = mgmt.mgmtWrite && mgmt.mgmtAddress == reconfig_pkg::A_S_CSR;
		mifTaken = st_reg.mifRd && !mifWaitrequest;
		st_next.xWr = '0;
		st_next.xRd = '0;

		// register file; reads are answered even while busy
		if (mgmt.mgmtRead) begin
			case (mgmt.mgmtAddress)
				reconfig_pkg::A_LCH, reconfig_pkg::A_S_LCH: st_next.rdata = {22'h0, st_reg.lch};
				reconfig_pkg::A_PHYS: st_next.rdata = {22'h0, physOf(st_reg.lch)};
				reconfig_pkg::A_CSR: st_next.rdata = {22'h0, st_reg.errReg, st_reg.busy, 8'h00};
				reconfig_pkg::A_S_CSR: st_next.rdata = {22'h0, st_reg.errStr, st_reg.busy, 5'h00, st_reg.direct, 2'b00};
				reconfig_pkg::A_OFFS, reconfig_pkg::A_S_OFFS: st_next.rdata = {26'h0, st_reg.offs};
				reconfig_pkg::A_DATA, reconfig_pkg::A_S_DATA: st_next.rdata = {16'h0, st_reg.data};
				reconfig_pkg::A_S_BASE: st_next.rdata = st_reg.mifBase;
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end

		// writes while busy are dropped; the host is expected to wait
		if (mgmt.mgmtWrite && !st_reg.busy) begin
			case (mgmt.mgmtAddress)
				reconfig_pkg::A_LCH, reconfig_pkg::A_S_LCH: st_next.lch = mgmt.mgmtWritedata[9:0];
				reconfig_pkg::A_OFFS, reconfig_pkg::A_S_OFFS: st_next.offs = mgmt.mgmtWritedata[5:0];
				reconfig_pkg::A_DATA, reconfig_pkg::A_S_DATA: st_next.data = mgmt.mgmtWritedata[15:0];
				reconfig_pkg::A_S_BASE: st_next.mifBase = mgmt.mgmtWritedata;
				reconfig_pkg::A_S_CSR: st_next.direct = mgmt.mgmtWritedata[reconfig_pkg::B_DIRECT];
				default: ;
			endcase
		end

		case (st_reg.state)
			S_IDLE: begin
				if (wrCsr && !st_reg.busy && (mgmt.mgmtWritedata[reconfig_pkg::B_WRITE] ||
						mgmt.mgmtWritedata[reconfig_pkg::B_READ])) begin
					if (lchOk && regModeOk(st_reg.offs[5:3])) begin
						st_next.errReg = 1'b0;
						st_next.readOp = mgmt.mgmtWritedata[reconfig_pkg::B_READ];
						st_next.fromStream = 1'b0;
						st_next.state = S_XFER;
					end else begin
						st_next.errReg = 1'b1;
					end
				end else if (wrScsr && !st_reg.busy && mgmt.mgmtWritedata[reconfig_pkg::B_WRITE]) begin
					st_next.errStr = 1'b0;
					st_next.direct = mgmt.mgmtWritedata[reconfig_pkg::B_DIRECT];
					if (!lchOk) begin
						st_next.errStr = 1'b1;
					end else if (mgmt.mgmtWritedata[reconfig_pkg::B_DIRECT]) begin
						if (streamOk(st_reg.offs[5:3])) begin
							st_next.readOp = 1'b0;
							st_next.fromStream = 1'b0;
							st_next.state = S_XFER;
						end else begin
							st_next.errStr = 1'b1;
						end
					end else begin
						st_next.mifAddr = st_reg.mifBase;
						st_next.mifRd = 1'b1;
						st_next.state = S_F_ENTRY;
					end
				end
			end
			S_CAL: begin
				// offset cancellation first, then duty cycle calibration if built
				if (st_reg.calCnt == 24'h000001) begin
					if (ENABLE_DCAL && !st_reg.dcalPhase) begin
						st_next.dcalPhase = 1'b1;
						st_next.calCnt = 24'(DCAL_CYCLES * NUM_CH);
					end else begin
						st_next.state = S_IDLE;
					end
				end else begin
					st_next.calCnt = st_reg.calCnt - 24'h000001;
				end
			end
			S_XFER: begin
				st_next.xAddr = st_reg.offs;
				st_next.xWdata = st_reg.data;
				st_next.xWr = st_reg.readOp ? '0 : selOf(st_reg.lch);
				st_next.xRd = st_reg.readOp ? selOf(st_reg.lch) : '0;
				st_next.state = S_XDONE;
			end
			S_XDONE: begin
				if (st_reg.readOp) begin
					st_next.data = xcvrReaddata[st_reg.lch[5:0]*16 +: 16];
				end
				st_next.state = st_reg.fromStream ? S_F_ENTRY : S_IDLE;
				st_next.mifRd = st_reg.fromStream;
			end
			S_F_ENTRY: begin
				if (mifTaken) begin
					st_next.mifAddr = st_reg.mifAddr + reconfig_pkg::MIF_WORD_BYTES;
					if (mifReaddata[reconfig_pkg::MIF_END_BIT]) begin
						st_next.mifRd = 1'b0;
						st_next.state = S_IDLE;
					end else begin
						st_next.offs = mifReaddata[5:0];
						st_next.state = S_F_DATA;
					end
				end
			end
			S_F_DATA: begin
				if (mifTaken) begin
					st_next.mifAddr = st_reg.mifAddr + reconfig_pkg::MIF_WORD_BYTES;
					st_next.mifRd = 1'b0;
					st_next.data = mifReaddata;
					st_next.state = S_APPLY;
				end
			end
			S_APPLY: begin
				// disallowed entries are skipped and flagged, the rest still apply
				if (streamOk(st_reg.offs[5:3])) begin
					st_next.readOp = 1'b0;
					st_next.fromStream = 1'b1;
					st_next.state = S_XFER;
				end else begin
					st_next.errStr = 1'b1;
					st_next.mifRd = 1'b1;
					st_next.state = S_F_ENTRY;
				end
			end
			default: st_next.state = S_IDLE;
		endcase

		st_next.busy = st_next.state != S_IDLE;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.state <= S_CAL;
			st_reg.calCnt <= 24'(OC_CYCLES * NUM_CH);
			st_reg.busy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mgmt.mgmtReaddata = st_reg.rdata;
	assign mgmt.reconfigBusy = st_reg.busy;
	assign mifAddress = st_reg.mifAddr;
	assign mifRead = st_reg.mifRd;
	assign xcvrWrite = st_reg.xWr;
	assign xcvrRead = st_reg.xRd;
	assign xcvrAddress = st_reg.xAddr;
	assign xcvrWritedata = st_reg.xWdata;
endmodule

// [verilog/reconfig_host.sv]
// Purpose: embedded controller end, turns APB orders into management accesses
// Assumes: same clock as the controller, APB with one wait-free access phase
// Notes: management writes wait for busy low; reads go straight out
`timescale 1ns/1ps
module reconfig_host (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	reconfig_mgmt_if.ctl mgmt
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_WAIT = 3'b010,
		H_CAP = 3'b100
	} hstate_t;

	typedef struct packed {
		hstate_t state;
		logic [6:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic rdValid;
		logic opRead;
		logic mWr;
		logic mRd;
		logic [31:0] prd;
		logic rdy;
		logic err;
	} host_t;

	host_t st_reg;
	host_t st_next;
	logic setup;
	logic access;
	logic mapped;

	always_comb begin
		st_next = st_reg;
		st_next.mWr = 1'b0;
		st_next.mRd = 1'b0;
		setup = psel && !penable;
		access = psel && penable && st_reg.rdy;
		mapped = paddr == reconfig_pkg::H_CMD || paddr == reconfig_pkg::H_ADDR ||
			paddr == reconfig_pkg::H_WDATA || paddr == reconfig_pkg::H_RDATA || paddr == reconfig_pkg::H_STATUS;
		st_next.rdy = setup;

		if (setup) begin
			st_next.err = !mapped || (pwrite && paddr == reconfig_pkg::H_CMD && st_reg.state != H_IDLE);
			case (paddr)
				reconfig_pkg::H_ADDR: st_next.prd = {25'h0, st_reg.addr};
				reconfig_pkg::H_WDATA: st_next.prd = st_reg.wdata;
				reconfig_pkg::H_RDATA: st_next.prd = st_reg.rdata;
				reconfig_pkg::H_STATUS: st_next.prd = {29'h0, st_reg.rdValid, mgmt.reconfigBusy, st_reg.state != H_IDLE};
				default: st_next.prd = 32'h0000_0000;
			endcase
		end

		if (access && pwrite && !st_reg.err) begin
			case (paddr)
				reconfig_pkg::H_ADDR: st_next.addr = pwdata[6:0];
				reconfig_pkg::H_WDATA: st_next.wdata = pwdata;
				reconfig_pkg::H_CMD: begin
					if (pwdata[reconfig_pkg::B_READ]) begin
						st_next.opRead = 1'b1;
						st_next.rdValid = 1'b0;
						st_next.state = H_WAIT;
					end else if (pwdata[reconfig_pkg::B_WRITE]) begin
						st_next.opRead = 1'b0;
						st_next.state = H_WAIT;
					end
				end
				default: ;
			endcase
		end

		case (st_reg.state)
			H_IDLE: ;
			H_WAIT: begin
				// reads poll status freely; writes may start an operation
				if (st_reg.opRead) begin
					st_next.mRd = 1'b1;
					st_next.state = H_CAP;
				end else if (!mgmt.reconfigBusy) begin
					st_next.mWr = 1'b1;
					st_next.state = H_IDLE;
				end
			end
			H_CAP: begin
				if (!st_reg.mRd) begin
					st_next.rdata = mgmt.mgmtReaddata;
					st_next.rdValid = 1'b1;
					st_next.state = H_IDLE;
				end
			end
			default: st_next.state = H_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.state <= H_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// address and data come from flops and stand across the strobe
	assign mgmt.mgmtAddress = st_reg.addr;
	assign mgmt.mgmtWritedata = st_reg.wdata;
	assign mgmt.mgmtWrite = st_reg.mWr;
	assign mgmt.mgmtRead = st_reg.mRd;
	assign prdata = st_reg.prd;
	assign pready = st_reg.rdy;
	assign pslverr = st_reg.err;
endmodule

// [verif/reconfig_mgmt_props.sv]
// Purpose: checks on the management port between host and controller
// Assumes: one clock, synchronous active-high reset
// Notes: init window is offset cancellation plus duty cycle, per channel
`timescale 1ns/1ps
module reconfig_mgmt_props #(
	parameter int NUM_CH = 2,
	parameter int OC_CYCLES = 5,
	parameter int DCAL_CYCLES = 3,
	parameter bit ENABLE_DCAL = 1'b1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [6:0] mgmtAddress,
	input wire logic [31:0] mgmtWritedata,
	input wire logic [31:0] mgmtReaddata,
	input wire logic mgmtWrite,
	input wire logic mgmtRead,
	input wire logic reconfigBusy
);
	localparam int INIT = (OC_CYCLES + (ENABLE_DCAL ? DCAL_CYCLES : 0)) * NUM_CH;
	logic [7:0] upCnt;
	logic initSeen;
	logic [9:0] lchShadow;
	logic mapped;
	assign mapped = (mgmtAddress inside {[7'h08:7'h0C]}) || (mgmtAddress inside {[7'h38:7'h3C]});
	// lch writes land only while idle, so the shadow follows the same gate
	always_ff @(posedge clock) begin
		if (reset) begin
			upCnt <= 8'h00;
			initSeen <= 1'b0;
			lchShadow <= 10'h000;
		end else begin
			if (upCnt != 8'hFF)
				upCnt <= upCnt + 8'h01;
			if (!reconfigBusy)
				initSeen <= 1'b1;
			if (mgmtWrite && !reconfigBusy && (mgmtAddress == 7'h08 || mgmtAddress == 7'h38))
				lchShadow <= mgmtWritedata[9:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	chk_write_pulse: assert property (mgmtWrite |=> !mgmtWrite)
		else $error("write strobe held past one cycle");
	chk_read_pulse: assert property (mgmtRead |=> !mgmtRead)
		else $error("read strobe held past one cycle");
	chk_host_waits: assert property (mgmtWrite |-> !reconfigBusy)
		else $error("write issued while busy");
	chk_busy_start: assert property ($fell(reset) |-> reconfigBusy)
		else $error("no calibration after reset");
	chk_init_length: assert property ($fell(reconfigBusy) && !initSeen |-> upCnt >= INIT - 1 && upCnt <= INIT + 2)
		else $error("calibration length off");
	chk_busy_cause: assert property ($rose(reconfigBusy) |-> $past(mgmtWrite) || $past(mgmtWrite, 2))
		else $error("busy without a command");
	chk_busy_bounded: assert property (reconfigBusy |-> ##[0:200] !reconfigBusy)
		else $error("operation never ends");
	chk_lch_read: assert property (mgmtRead && mgmtAddress == 7'h08 |=> mgmtReaddata[9:0] == $past(lchShadow))
		else $error("channel register readback wrong");
	chk_unmapped_zero: assert property (mgmtRead && !mapped |=> mgmtReaddata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_read_stands: assert property (!mgmtRead |=> $stable(mgmtReaddata))
		else $error("read data changed without read");
	chk_busy_bit: assert property (mgmtRead && mgmtAddress == 7'h0A |=> mgmtReaddata[8] == $past(reconfigBusy))
		else $error("busy bit disagrees with busy");
	cover property (mgmtWrite && mgmtAddress == 7'h0A);
	cover property (mgmtWrite && mgmtAddress == 7'h3A);
	cover property ($fell(reconfigBusy) && initSeen);
endmodule

// [verif/transceiver_reconfig_access_modes_bench.sv]
// Purpose: host and controller joined, driven over APB and file memory
// Assumes: 10 MHz clock, calibration counts shortened to 5 and 3
// Notes: file memory answers combinationally, stalls at random
`timescale 1ns/1ps
module transceiver_reconfig_access_modes_bench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] mifAddress;
	logic mifRead;
	logic [15:0] mifReaddata;
	logic mifWaitrequest = 1'b0;
	logic [2:0] xcvrWrite;
	logic [2:0] xcvrRead;
	logic [5:0] xcvrAddress;
	logic [15:0] xcvrWritedata;
	logic [47:0] xcvrReaddata = 48'h0;
	logic [15:0] fileMem [0:31];
	logic [15:0] tick = 16'h0000;
	logic stallPrev = 1'b0;
	logic [31:0] addrPrev = 32'h0;
	logic [31:0] wq [$];
	logic [31:0] aq [$];
	integer seed = 32'h7D9C;
	int errors = 0;
	int cmp_count = 0;
	always #50 clock = ~clock;
	reconfig_mgmt_if reconfig_mgmt_if_i ();
	reconfig_host reconfig_host_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mgmt(reconfig_mgmt_if_i));
	reconfig_controller #(.OC_CYCLES(5), .DCAL_CYCLES(3)) reconfig_controller_i (
		.clock(clock), .reset(reset), .mgmt(reconfig_mgmt_if_i), .mifAddress(mifAddress), .mifRead(mifRead),
		.mifReaddata(mifReaddata), .mifWaitrequest(mifWaitrequest), .xcvrWrite(xcvrWrite), .xcvrRead(xcvrRead),
		.xcvrAddress(xcvrAddress), .xcvrWritedata(xcvrWritedata), .xcvrReaddata(xcvrReaddata));
	reconfig_mgmt_props #(.OC_CYCLES(5), .DCAL_CYCLES(3)) reconfig_mgmt_props_i (
		.clock(clock), .reset(reset), .mgmtAddress(reconfig_mgmt_if_i.mgmtAddress),
		.mgmtWritedata(reconfig_mgmt_if_i.mgmtWritedata), .mgmtReaddata(reconfig_mgmt_if_i.mgmtReaddata),
		.mgmtWrite(reconfig_mgmt_if_i.mgmtWrite), .mgmtRead(reconfig_mgmt_if_i.mgmtRead),
		.reconfigBusy(reconfig_mgmt_if_i.reconfigBusy));
	// data is only good on an accepted read; otherwise a moving pattern
	assign mifReaddata = (mifRead && !mifWaitrequest) ? fileMem[mifAddress[5:1]] : ~tick;
	task cmp_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task final_report;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic reg_ok(input logic [2:0] c);
		return c <= 3'h5;
	endfunction
	function automatic logic file_ok(input logic [2:0] c);
		return c == 3'h0 || c >= 3'h5;
	endfunction
	always @(posedge clock) begin
		tick <= tick + 16'h0001;
		mifWaitrequest <= 1'($random(seed));
		if (reset) begin
			stallPrev <= 1'b0;
		end else begin
			if (stallPrev) begin
				cmp_bit(mifRead, 1'b1);
				cmp_word(mifAddress, addrPrev);
			end
			stallPrev <= mifRead & mifWaitrequest;
			addrPrev <= mifAddress;
			if (mifRead && !mifWaitrequest)
				aq.push_back(mifAddress);
			if (|xcvrWrite)
				wq.push_back({7'h0, xcvrWrite, xcvrAddress, xcvrWritedata});
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_status(input logic [31:0] mask, input logic [31:0] want);
		logic [31:0] q;
		logic e;
		int n;
		n = 0;
		do begin
			apb(1'b0, reconfig_pkg::H_STATUS, 32'h0, q, e);
			n++;
		end while ((q & mask) !== want && n < 100);
		if (n >= 100)
			errors++;
	endtask
	task mgmt_wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, reconfig_pkg::H_ADDR, {25'h0, a}, q, e);
		apb(1'b1, reconfig_pkg::H_WDATA, d, q, e);
		apb(1'b1, reconfig_pkg::H_CMD, 32'h1, q, e);
		// busy only shows a few cycles after the command
		repeat (3) @(posedge clock);
		wait_status(32'h3, 32'h0);
	endtask
	task mgmt_rd(input logic [6:0] a, output logic [31:0] q);
		logic e;
		apb(1'b1, reconfig_pkg::H_ADDR, {25'h0, a}, q, e);
		apb(1'b1, reconfig_pkg::H_CMD, 32'h2, q, e);
		wait_status(32'h5, 32'h4);
		apb(1'b0, reconfig_pkg::H_RDATA, 32'h0, q, e);
	endtask
	initial begin
		#2000000;
		errors++;
		final_report;
	end
	initial begin
		logic [31:0] q;
		logic e;
		logic [2:0] c;
		logic [1:0] l;
		logic [15:0] d;
		logic [5:0] off;
		logic [2:0] fcls [0:4];
		int k;
		int m;
		for (k = 0; k < 32; k++)
			fileMem[k] = 16'h8000;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		apb(1'b0, reconfig_pkg::H_STATUS, 32'h0, q, e);
		cmp_bit(q[1], 1'b1);
		apb(1'b1, reconfig_pkg::H_CMD, 32'h1, q, e);
		cmp_bit(e, 1'b0);
		apb(1'b1, reconfig_pkg::H_CMD, 32'h1, q, e);
		cmp_bit(e, 1'b1);
		wait_status(32'h3, 32'h0);
		apb(1'b0, 8'h14, 32'h0, q, e);
		cmp_bit(e, 1'b1);
		mgmt_rd(7'h20, q);
		cmp_word(q, 32'h0);
		for (k = 0; k < 8; k++) begin
			c = k[2:0];
			l = 2'(($random(seed) & 32'h7FFF_FFFF) % 3);
			d = 16'($random(seed));
			off = {c, 3'($random(seed))};
			mgmt_wr(reconfig_pkg::A_LCH, {30'h0, l});
			mgmt_rd(reconfig_pkg::A_PHYS, q);
			cmp_word(q, {30'h0, l});
			mgmt_rd(reconfig_pkg::A_LCH, q);
			cmp_word(q, {30'h0, l});
			mgmt_wr(reconfig_pkg::A_OFFS, {26'h0, off});
			mgmt_wr(reconfig_pkg::A_DATA, {16'h0, d});
			wq.delete();
			mgmt_wr(reconfig_pkg::A_CSR, 32'h1);
			cmp_word(32'(wq.size()), {31'h0, reg_ok(c)});
			if (wq.size() == 1)
				cmp_word(wq[0], {7'h0, 3'b001 << l, off, d});
			mgmt_rd(reconfig_pkg::A_CSR, q);
			cmp_bit(q[reconfig_pkg::B_ERR], !reg_ok(c));
			xcvrReaddata <= {$random(seed), 16'($random(seed))};
			mgmt_wr(reconfig_pkg::A_OFFS, 32'h0);
			mgmt_wr(reconfig_pkg::A_CSR, 32'h2);
			mgmt_rd(reconfig_pkg::A_DATA, q);
			cmp_word(q, {16'h0, xcvrReaddata[l * 16 +: 16]});
		end
		// channel number past the last interface must be refused
		mgmt_wr(reconfig_pkg::A_LCH, 32'h3);
		wq.delete();
		mgmt_wr(reconfig_pkg::A_CSR, 32'h1);
		mgmt_rd(reconfig_pkg::A_CSR, q);
		cmp_bit(q[reconfig_pkg::B_ERR], 1'b1);
		cmp_word(32'(wq.size()), 32'd0);
		fcls = '{3'h0, 3'h6, 3'h7, 3'h1, 3'h5};
		for (k = 0; k < 5; k++) begin
			fileMem[8 + 2 * k] = {10'h0, fcls[k], 3'(k)};
			fileMem[9 + 2 * k] = 16'($random(seed)) & 16'h7FFF;
		end
		mgmt_wr(reconfig_pkg::A_S_LCH, 32'h1);
		mgmt_wr(reconfig_pkg::A_S_BASE, 32'h10);
		wq.delete();
		aq.delete();
		mgmt_wr(reconfig_pkg::A_S_CSR, 32'h1);
		cmp_word(32'(aq.size()), 32'd11);
		for (k = 0; k < 11; k++)
			cmp_word(aq[k], 32'h10 + 32'(k) * reconfig_pkg::MIF_WORD_BYTES);
		cmp_word(32'(wq.size()), 32'd4);
		m = 0;
		for (k = 0; k < 5; k++) begin
			if (file_ok(fcls[k])) begin
				cmp_word(wq[m], {7'h0, 3'b010, fileMem[8 + 2 * k][5:0], fileMem[9 + 2 * k]});
				m++;
			end
		end
		mgmt_rd(reconfig_pkg::A_S_CSR, q);
		cmp_bit(q[reconfig_pkg::B_ERR], 1'b1);
		// direct write: one allowed class, then one streamer may not touch
		off = {3'h6, 3'h2};
		d = 16'($random(seed));
		mgmt_wr(reconfig_pkg::A_S_OFFS, {26'h0, off});
		mgmt_wr(reconfig_pkg::A_S_DATA, {16'h0, d});
		wq.delete();
		mgmt_wr(reconfig_pkg::A_S_CSR, 32'h5);
		cmp_word(32'(wq.size()), 32'd1);
		cmp_word(wq[0], {7'h0, 3'b010, off, d});
		mgmt_wr(reconfig_pkg::A_S_OFFS, 32'h08);
		wq.delete();
		mgmt_wr(reconfig_pkg::A_S_CSR, 32'h5);
		cmp_word(32'(wq.size()), 32'd0);
		mgmt_wr(reconfig_pkg::A_S_CSR, 32'h1 << reconfig_pkg::B_DIRECT);
		mgmt_rd(reconfig_pkg::A_S_CSR, q);
		cmp_bit(q[reconfig_pkg::B_DIRECT], 1'b1);
		cmp_bit(q[reconfig_pkg::B_ERR], 1'b1);
		reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		apb(1'b0, reconfig_pkg::H_STATUS, 32'h0, q, e);
		cmp_bit(q[1], 1'b1);
		wait_status(32'h3, 32'h0);
		final_report;
	end
endmodule
